// file: src/slc_pkg.sv
// Package for the synthesizer latch bank: field positions, address codes, timing.
// Assumes both ends and the checker import it whole.
package slc_pkg;
	localparam int WORD_BITS = 24;
	// Address codes, {latch_addr_high, latch_addr_low} in bits 1:0
	localparam logic [1:0] ADDR_CONTROL = 2'h0;
	localparam logic [1:0] ADDR_FEEDBACK = 2'h2;
	localparam logic [1:0] ADDR_REFERENCE = 2'h1;
	// Control word fields
	localparam int CTL_COUNTER_RESET = 4;
	localparam int CTL_PUMP_TRISTATE = 3;
	localparam int CTL_POLARITY = 8;
	localparam int CTL_PUMP_GAIN = 10;
	localparam int CTL_MUTE_LOCK = 11;
	localparam int CTL_PUMP_ONE_LSB = 14;
	localparam int CTL_PUMP_TWO_LSB = 17;
	localparam int CTL_PD_REQUEST = 20;
	localparam int CTL_PD_MODE = 21;
	localparam int CTL_PRESCALER_LSB = 22;
	// Feedback word fields
	localparam int FB_SWALLOW_LSB = 2;
	localparam int FB_SWALLOW_W = 5;
	localparam int FB_MAIN_LSB = 8;
	localparam int FB_MAIN_W = 13;
	localparam int FB_PUMP_GAIN = 21;
	localparam int FB_DIV2 = 22;
	localparam int FB_DIV2_SEL = 23;
	// Reference word fields
	localparam int REF_DIV_LSB = 2;
	localparam int REF_DIV_W = 14;
	localparam int REF_LOCK_PREC = 18;
	localparam int REF_TEST = 19;
	localparam int REF_BAND_LSB = 20;
	// Reset values
	localparam logic [23:0] CONTROL_RESET = 24'h00_0000;
	localparam logic [23:0] FEEDBACK_RESET = 24'h00_0000;
	localparam logic [23:0] REFERENCE_RESET = 24'h00_0005; // Divide ratio 1 in bits 15:2, address 01
	// Lock counts
	localparam logic [2:0] LOCK_CYCLES_FINE = 3'h5;
	localparam logic [2:0] LOCK_CYCLES_COARSE = 3'h3;
	// Host timing
	localparam int CLOCK_HZ = 10_000_000;
	localparam int SETTLE_LONG_US = 5000;
	localparam int SETTLE_SHORT_US = 600;
	localparam int SETTLE_LONG_CYCLES = (SETTLE_LONG_US * (CLOCK_HZ / 1_000_000));
	localparam int SETTLE_SHORT_CYCLES = (SETTLE_SHORT_US * (CLOCK_HZ / 1_000_000));
	localparam int SCLK_HALF_CYCLES = 4;
	// Power-down states
	typedef enum logic [2:0] {
		SLC_PD_RUN = 3'b001,
		SLC_PD_WAIT1 = 3'b010,
		SLC_PD_DOWN = 3'b100
	} slc_pd_state_t;
	// Host sequencer states
	typedef enum logic [3:0] {
		SLC_H_IDLE = 4'b0001,
		SLC_H_SHIFT = 4'b0010,
		SLC_H_LOAD = 4'b0100,
		SLC_H_WAIT = 4'b1000
	} slc_host_state_t;
endpackage

// file: src/slc_link_if.sv
// Three-wire serial link between the host and the latch bank.
// Assumes the bench connects both modports and drives i_clock of both ends.
`timescale 1ns/100ps
interface slc_link_if;
	logic sclk;
	logic sdata;
	logic load_strobe;
	logic chip_enable;
	modport host (output sclk, output sdata, output load_strobe, output chip_enable);
	modport dev (input sclk, input sdata, input load_strobe, input chip_enable);
endinterface

// file: src/slc_latch_bank.sv
// Latch bank end: serial shift register, three word latches, power-down control.
// Assumes link pins are asynchronous; the reference divider output comes from analog counters.
`timescale 1ns/100ps
module slc_latch_bank import slc_pkg::*; (
	input wire logic i_clock,
	input wire logic i_rst,
	slc_link_if.dev link,
	input wire logic i_ref_out,
	input wire logic i_phase_ok,
	output logic o_powered_down,
	output logic o_counters_held,
	output logic o_pump_tristate,
	output logic o_pump_polarity,
	output logic [2:0] o_pump_current,
	output logic o_rf_enable,
	output logic o_ref_buffer_en,
	output logic o_locked,
	output logic [1:0] o_prescaler,
	output logic [4:0] o_swallow,
	output logic [12:0] o_main,
	output logic [17:0] o_total_div,
	output logic o_div2_enable,
	output logic o_div2_to_prescaler,
	output logic [13:0] o_ref_divide,
	output logic o_band_clock
);
	logic [4:0] sync1_ff;
	logic [4:0] sync2_ff;
	logic sclk_d_ff;
	logic le_d_ff;
	logic ref1_ff;
	logic ref2_ff;
	logic ref_d_ff;
	logic [23:0] shift_ff;
	logic [23:0] control_ff;
	logic [23:0] feedback_ff;
	logic [23:0] reference_ff;
	logic gain_ff;
	logic [2:0] lock_cnt_ff;
	logic [2:0] band_cnt_ff;
	slc_pd_state_t pd_ff;
	slc_pd_state_t nxt_pd;
	logic sclk_rise;
	logic le_rise;
	logic ref_rise;
	logic pd_active;
	logic [2:0] lock_need;
	logic [2:0] band_mask;

	// Two-stage synchronisers; only stage two is read by logic
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			sync1_ff <= 5'h04; // Strobe idles high, so no false latch after reset
			sync2_ff <= 5'h04;
			ref1_ff <= 1'b0;
			ref2_ff <= 1'b0;
		end else begin
			sync1_ff <= {i_phase_ok, link.chip_enable, link.load_strobe, link.sdata, link.sclk};
			sync2_ff <= sync1_ff;
			ref1_ff <= i_ref_out;
			ref2_ff <= ref1_ff;
		end
	end

	// Edge detect registers
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			sclk_d_ff <= 1'b0;
			le_d_ff <= 1'b1;
			ref_d_ff <= 1'b0;
		end else begin
			sclk_d_ff <= sync2_ff[0];
			le_d_ff <= sync2_ff[2];
			ref_d_ff <= ref2_ff;
		end
	end
	assign sclk_rise = sync2_ff[0] & ~sclk_d_ff;
	assign le_rise = sync2_ff[2] & ~le_d_ff;
	assign ref_rise = ref2_ff & ~ref_d_ff;

	// Shift register never gated by power-down, so words still load there
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			shift_ff <= 24'h00_0000;
		end else if (sclk_rise) begin
			shift_ff <= {shift_ff[22:0], sync2_ff[1]};
		end
	end

	// Latch transfer on strobe rise, decoded by the two address bits
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			control_ff <= CONTROL_RESET;
			feedback_ff <= FEEDBACK_RESET;
			reference_ff <= REFERENCE_RESET;
		end else if (le_rise) begin
			unique case (shift_ff[1:0])
				ADDR_CONTROL: control_ff <= shift_ff;
				ADDR_FEEDBACK: feedback_ff <= shift_ff;
				ADDR_REFERENCE: reference_ff <= shift_ff;
				default: ; // Address 11 selects no latch here
			endcase
		end
	end

	// Gain bit shared by two words; whichever was written last holds
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			gain_ff <= 1'b0;
		end else if (le_rise && shift_ff[1:0] == ADDR_CONTROL) begin
			gain_ff <= shift_ff[CTL_PUMP_GAIN];
		end else if (le_rise && shift_ff[1:0] == ADDR_FEEDBACK) begin
			gain_ff <= shift_ff[FB_PUMP_GAIN];
		end
	end

	// Power-down state: asynchronous mode now, synchronous waits two reference edges
	always_comb begin
		nxt_pd = pd_ff;
		unique case (pd_ff)
			SLC_PD_RUN: begin
				if (le_rise && shift_ff[1:0] == ADDR_CONTROL && shift_ff[CTL_PD_REQUEST]) begin
					nxt_pd = shift_ff[CTL_PD_MODE] ? SLC_PD_WAIT1 : SLC_PD_DOWN;
				end
			end
			SLC_PD_WAIT1: begin
				// A strobe rise counts as edge zero; the second reference edge moves on, once ref_seen_ff is set
				if (ref_rise) begin
					nxt_pd = SLC_PD_DOWN;
				end
			end
			SLC_PD_DOWN: begin
				if (!control_ff[CTL_PD_REQUEST]) begin
					nxt_pd = SLC_PD_RUN;
				end
			end
			default: nxt_pd = SLC_PD_RUN;
		endcase
		// Writing the request bit to zero leaves power-down at any point, except on the cycle of the first reference edge in SLC_PD_WAIT1
		if (le_rise && shift_ff[1:0] == ADDR_CONTROL && !shift_ff[CTL_PD_REQUEST]) begin
			nxt_pd = SLC_PD_RUN;
		end
	end

	// Extra waiting stage counter: a second reference edge is required before down
	logic ref_seen_ff;
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			pd_ff <= SLC_PD_RUN;
			ref_seen_ff <= 1'b0;
		end else if (pd_ff == SLC_PD_WAIT1 && ref_rise && !ref_seen_ff) begin
			ref_seen_ff <= 1'b1;
		end else begin
			ref_seen_ff <= ref_seen_ff && (nxt_pd == SLC_PD_WAIT1); // Held until the second edge
			pd_ff <= nxt_pd;
		end
	end

	assign pd_active = (pd_ff == SLC_PD_DOWN) || !sync2_ff[3];

	// Lock detect: count good reference cycles, cleared whenever the loop is down
	assign lock_need = reference_ff[REF_LOCK_PREC] ? LOCK_CYCLES_FINE : LOCK_CYCLES_COARSE;
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			lock_cnt_ff <= 3'h0;
		end else if (pd_active || control_ff[CTL_COUNTER_RESET]) begin
			lock_cnt_ff <= 3'h0;
		end else if (ref_rise) begin
			if (!sync2_ff[4]) begin
				lock_cnt_ff <= 3'h0;
			end else if (lock_cnt_ff < lock_need) begin
				lock_cnt_ff <= lock_cnt_ff + 3'h1;
			end
		end
	end

	// Band select clock: reference output divided by 1, 2, 4 or 8
	always_comb begin
		unique case (reference_ff[REF_BAND_LSB +: 2])
			2'h0: band_mask = 3'h0;
			2'h1: band_mask = 3'h1;
			2'h2: band_mask = 3'h3;
			default: band_mask = 3'h7;
		endcase
	end
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			band_cnt_ff <= 3'h0;
			o_band_clock <= 1'b0;
		end else if (pd_active) begin
			band_cnt_ff <= 3'h0;
			o_band_clock <= 1'b0;
		end else begin
			if (ref_rise) begin
				band_cnt_ff <= (band_cnt_ff + 3'h1) & band_mask;
			end
			o_band_clock <= (band_mask == 3'h0) ? ref2_ff : ((band_cnt_ff & band_mask) == 3'h0);
		end
	end

	// Registered outputs; test bit is never acted on, so test latch is ignored
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_powered_down <= 1'b1;
			o_counters_held <= 1'b1;
			o_pump_tristate <= 1'b1;
			o_pump_polarity <= 1'b0;
			o_pump_current <= 3'h0;
			o_rf_enable <= 1'b0;
			o_ref_buffer_en <= 1'b0;
			o_locked <= 1'b0;
			o_prescaler <= 2'h0;
			o_swallow <= 5'h00;
			o_main <= 13'h0000;
			o_total_div <= 18'h0_0000;
			o_div2_enable <= 1'b0;
			o_div2_to_prescaler <= 1'b0;
			o_ref_divide <= 14'h0001;
		end else begin
			o_powered_down <= pd_active;
			o_counters_held <= pd_active || control_ff[CTL_COUNTER_RESET];
			o_pump_tristate <= pd_active || control_ff[CTL_PUMP_TRISTATE];
			o_pump_polarity <= control_ff[CTL_POLARITY];
			o_pump_current <= gain_ff ? control_ff[CTL_PUMP_TWO_LSB +: 3]
				: control_ff[CTL_PUMP_ONE_LSB +: 3];
			o_rf_enable <= !pd_active && !(control_ff[CTL_MUTE_LOCK] && !o_locked);
			o_ref_buffer_en <= !pd_active;
			o_locked <= !pd_active && (lock_cnt_ff >= lock_need);
			o_prescaler <= control_ff[CTL_PRESCALER_LSB +: 2];
			o_swallow <= feedback_ff[FB_SWALLOW_LSB +: FB_SWALLOW_W];
			o_main <= feedback_ff[FB_MAIN_LSB +: FB_MAIN_W];
			// Prescaler modulus is 8, 16, 32 or 64 from the two select bits
			o_total_div <= 18'((feedback_ff[FB_MAIN_LSB +: FB_MAIN_W] << (3 + int'(control_ff[CTL_PRESCALER_LSB +: 2])))
				+ feedback_ff[FB_SWALLOW_LSB +: FB_SWALLOW_W]);
			o_div2_enable <= feedback_ff[FB_DIV2];
			o_div2_to_prescaler <= feedback_ff[FB_DIV2_SEL];
			o_ref_divide <= reference_ff[REF_DIV_LSB +: REF_DIV_W];
		end
	end
endmodule // slc_latch_bank

// file: src/slc_host.sv
// Host end: sends reference, control and feedback words over the three-wire link.
// Assumes the user pulses i_start with the three words stable until o_done.
`timescale 1ns/100ps
module slc_host import slc_pkg::*; #(
	parameter int SETTLE_CYCLES = SETTLE_LONG_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_rst,
	slc_link_if.host link,
	input wire logic i_start,
	input wire logic i_single,
	input wire logic [1:0] i_single_sel,
	input wire logic i_chip_enable,
	input wire logic [23:0] i_control,
	input wire logic [23:0] i_feedback,
	input wire logic [23:0] i_reference,
	output logic o_busy,
	output logic o_done
);
	slc_host_state_t st_ff;
	logic [23:0] sh_ff;
	logic [4:0] bit_ff;
	logic [2:0] half_ff;
	logic [1:0] word_ff;
	logic single_ff;
	logic [31:0] wait_ff;
	logic sclk_ff;
	logic le_ff;
	logic ce_ff;

	// Word choice: 0 reference, 1 control, 2 feedback; reserved bits cleared
	function automatic logic [23:0] pick(input logic [1:0] w);
		logic [23:0] v;
		v = 24'h00_0000;
		unique case (w)
			2'h0: v = {2'h0, i_reference[21:2], ADDR_REFERENCE};
			2'h1: v = {i_control[23:2], ADDR_CONTROL};
			default: v = {i_feedback[23:8], 1'b0, i_feedback[6:2], ADDR_FEEDBACK};
		endcase
		v[REF_TEST] = (w == 2'h0) ? 1'b0 : v[REF_TEST];
		return v;
	endfunction

	// Sequencer: full load goes reference, control, wait, feedback
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			st_ff <= SLC_H_IDLE;
			sh_ff <= 24'h00_0000;
			bit_ff <= 5'h00;
			half_ff <= 3'h0;
			word_ff <= 2'h0;
			single_ff <= 1'b0;
			wait_ff <= 32'h0000_0000;
			sclk_ff <= 1'b0;
			le_ff <= 1'b1;
			o_done <= 1'b0;
			o_busy <= 1'b0;
		end else begin
			o_done <= 1'b0;
			unique case (st_ff)
				SLC_H_IDLE: begin
					if (i_start) begin
						word_ff <= i_single ? i_single_sel : 2'h0;
						sh_ff <= pick(i_single ? i_single_sel : 2'h0);
						single_ff <= i_single;
						bit_ff <= 5'h00;
						half_ff <= 3'h0;
						le_ff <= 1'b0;
						o_busy <= 1'b1;
						st_ff <= SLC_H_SHIFT;
					end
				end
				SLC_H_SHIFT: begin
					// Data moves on the fall, device samples on the rise
					if (half_ff == 3'(SCLK_HALF_CYCLES - 1)) begin
						half_ff <= 3'h0;
						sclk_ff <= ~sclk_ff;
						if (sclk_ff) begin
							sh_ff <= {sh_ff[22:0], 1'b0};
							bit_ff <= bit_ff + 5'h01;
							if (bit_ff == 5'(WORD_BITS - 1)) begin
								st_ff <= SLC_H_LOAD;
							end
						end
					end else begin
						half_ff <= half_ff + 3'h1;
					end
				end
				SLC_H_LOAD: begin
					le_ff <= 1'b1;
					wait_ff <= (word_ff == 2'h1) ? 32'(SETTLE_CYCLES) : 32'h0000_0004;
					st_ff <= SLC_H_WAIT;
				end
				default: begin
					// Settle gap after the control word before the feedback word
					if (wait_ff != 32'h0000_0000) begin
						wait_ff <= wait_ff - 32'h0000_0001;
					end else if (single_ff || word_ff == 2'h2) begin
						o_busy <= 1'b0;
						o_done <= 1'b1;
						st_ff <= SLC_H_IDLE;
					end else begin
						word_ff <= word_ff + 2'h1;
						sh_ff <= pick(word_ff + 2'h1);
						bit_ff <= 5'h00;
						le_ff <= 1'b0;
						st_ff <= SLC_H_SHIFT;
					end
				end
			endcase
		end
	end

	// Chip enable follows the user request
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ce_ff <= 1'b0;
		end else begin
			ce_ff <= i_chip_enable;
		end
	end

	assign link.sclk = sclk_ff;
	assign link.sdata = sh_ff[23];
	assign link.load_strobe = le_ff;
	assign link.chip_enable = ce_ff;
endmodule // slc_host

// file: tb/slc_link_checker.sv
// Checker for the three-wire link: framing, timing, word order and reserved bits sent by the host.
// Assumes it sits beside the link interface and shares the host's clock and reset.
`timescale 1ns/100ps
module slc_link_checker import slc_pkg::*; #(
	parameter int SETTLE_CYCLES = SETTLE_LONG_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic sclk,
	input wire logic sdata,
	input wire logic load_strobe,
	input wire logic chip_enable
);
	logic sclk_d_ff;
	logic strobe_d_ff;
	logic [23:0] shift_ff;
	logic [5:0] rises_ff;
	logic [1:0] frames_ff;
	logic [19:0] gap_ff;
	wire sclk_rise = sclk && !sclk_d_ff;
	wire latch = load_strobe && !strobe_d_ff;
	// Edge history; strobe idles high, so it resets high to avoid a false latch
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			sclk_d_ff <= 1'h0;
			strobe_d_ff <= 1'h1;
		end else begin
			sclk_d_ff <= sclk;
			strobe_d_ff <= load_strobe;
		end
	end
	// Shadow of the bank's shift register, counted per frame
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			shift_ff <= 24'h00_0000;
			rises_ff <= 6'h00;
		end else begin
			if (sclk_rise)
				shift_ff <= {shift_ff[22:0], sdata};
			if (!load_strobe && strobe_d_ff)
				rises_ff <= 6'h00;
			else if (sclk_rise && !load_strobe)
				rises_ff <= rises_ff + 6'h01;
		end
	end
	// Frames since reset (saturating) and cycles since the last control latch
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			frames_ff <= 2'h0;
			gap_ff <= 20'h0_0000;
		end else begin
			if (latch && frames_ff != 2'h3)
				frames_ff <= frames_ff + 2'h1;
			if (latch && shift_ff[1:0] == ADDR_CONTROL)
				gap_ff <= 20'h0_0000;
			else if (gap_ff != 20'hf_ffff)
				gap_ff <= gap_ff + 20'h0_0001;
		end
	end
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	property p_idle_clock; load_strobe |-> !sclk; endproperty
	a_idle_clock: assert property (p_idle_clock) else $error("serial clock moved outside a frame");
	property p_frame_bits; $rose(load_strobe) |-> rises_ff == 6'h18; endproperty
	a_frame_bits: assert property (p_frame_bits) else $error("frame not 24 clock rises");
	property p_half_period; $rose(sclk) |-> sclk [*4] ##1 !sclk; endproperty
	a_half_period: assert property (p_half_period) else $error("serial clock high time wrong");
	property p_data_steady; sclk && $past(sclk) |-> $stable(sdata); endproperty
	a_data_steady: assert property (p_data_steady) else $error("data moved while clock high");
	property p_strobe_hold; $rose(load_strobe) |-> load_strobe [*4]; endproperty
	a_strobe_hold: assert property (p_strobe_hold) else $error("strobe high too short");
	property p_order;
		latch && frames_ff != 2'h3 |-> shift_ff[1:0] ==
			(frames_ff == 2'h0 ? ADDR_REFERENCE : (frames_ff == 2'h1 ? ADDR_CONTROL : ADDR_FEEDBACK));
	endproperty
	a_order: assert property (p_order) else $error("start-up words out of order");
	property p_settle; latch && frames_ff == 2'h2 |-> gap_ff >= SETTLE_CYCLES; endproperty
	a_settle: assert property (p_settle) else $error("feedback word sent too soon");
	property p_enabled_start; latch && frames_ff == 2'h0 |-> chip_enable; endproperty
	a_enabled_start: assert property (p_enabled_start) else $error("start-up word sent with chip disabled");
	property p_reserved;
		latch |-> !(shift_ff[1:0] == ADDR_FEEDBACK && shift_ff[7]) &&
			!(shift_ff[1:0] == ADDR_REFERENCE && |shift_ff[23:22]);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit sent as one");
	property p_test_bit; latch && shift_ff[1:0] == ADDR_REFERENCE |-> !shift_ff[19]; endproperty
	a_test_bit: assert property (p_test_bit) else $error("test bit sent as one");
endmodule // slc_link_checker

// file: tb/synth_latch_power_control_tb.sv
// Bench: host and latch bank joined by the link; user-side calls with expected results.
// Assumes package, interface, both ends and the checker are compiled first.
`timescale 1ns/100ps
module synth_latch_power_control_tb import slc_pkg::*;;
	logic i_clock = 0, i_rst = 1, start = 0, single = 0, ce = 0, ok = 0, rg = 0, rm = 0, run = 1;
	logic [1:0] sel = 0;
	logic [23:0] ctl = 0, fb = 0, rf = 0;
	logic pd, held, tri_s, pol, rf_en, buf_en, lock, d2, d2p, band, busy, done;
	logic [2:0] cur;
	logic [1:0] presc;
	logic [4:0] sw;
	logic [12:0] mn;
	logic [17:0] tot;
	logic [13:0] rdiv;
	int errors = 0, n_tests = 0, cyc = 0, bands = 0;
	wire ref_w = run ? rg : rm;
	slc_link_if slc_link_if_i();
	slc_host #(.SETTLE_CYCLES(200)) slc_host_i(.i_clock(i_clock), .i_rst(i_rst), .link(slc_link_if_i),
		.i_start(start), .i_single(single), .i_single_sel(sel), .i_chip_enable(ce), .i_control(ctl),
		.i_feedback(fb), .i_reference(rf), .o_busy(busy), .o_done(done));
	slc_latch_bank slc_latch_bank_i(.i_clock(i_clock), .i_rst(i_rst), .link(slc_link_if_i), .i_ref_out(ref_w),
		.i_phase_ok(ok), .o_powered_down(pd), .o_counters_held(held), .o_pump_tristate(tri_s),
		.o_pump_polarity(pol), .o_pump_current(cur), .o_rf_enable(rf_en), .o_ref_buffer_en(buf_en),
		.o_locked(lock), .o_prescaler(presc), .o_swallow(sw), .o_main(mn), .o_total_div(tot),
		.o_div2_enable(d2), .o_div2_to_prescaler(d2p), .o_ref_divide(rdiv), .o_band_clock(band));
	slc_link_checker #(.SETTLE_CYCLES(200)) slc_link_checker_i(.i_clock(i_clock), .i_rst(i_rst),
		.sclk(slc_link_if_i.sclk), .sdata(slc_link_if_i.sdata), .load_strobe(slc_link_if_i.load_strobe),
		.chip_enable(slc_link_if_i.chip_enable));
	// Clocks; the reference output is free-running unless a test pulses it by hand
	initial forever #50 i_clock = ~i_clock;
	initial forever #400 rg = ~rg;
	always @(posedge band) bands++;
	// Hang guard: the whole run needs well under 8000 cycles
	always @(posedge i_clock) begin
		cyc++;
		if (cyc > 20000) begin
			errors++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("errors %0d n_tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	// One host request; outputs settle within a few cycles of the strobe, so 8 are given
	task automatic go(input logic s, input logic [1:0] w);
		int k;
		single = s;
		sel = w;
		start = 1;
		tick(1);
		start = 0;
		chk(busy, 1);
		for (k = 0; k < 3000 && done !== 1'b1; k++)
			tick(1);
		chk(k < 3000, 1);
		chk(busy, 0);
		tick(8);
	endtask
	task automatic rises(input int n);
		repeat (n) @(posedge ref_w);
		tick(6);
	endtask
	task automatic pulse();
		tick(4);
		rm = 1;
		tick(4);
		rm = 0;
		tick(6);
	endtask
	function automatic logic [23:0] cw(logic [1:0] p, logic g, logic po, logic mu, logic h, logic t);
		return {2'h1, p, 3'h5, 3'h3, 2'h0, mu, g, 1'h0, po, 3'h0, h, t, 3'h0};
	endfunction
	function automatic logic [23:0] fw(logic [4:0] s, logic [12:0] m, logic g);
		return {1'h0, 1'h1, g, m, 1'h0, s, 2'h0};
	endfunction
	function automatic logic [23:0] rw(logic [13:0] d, logic p);
		return {2'h0, 2'h1, 1'h0, p, 2'h0, d, 2'h0};
	endfunction
	// Main sequence
	initial begin
		tick(16);
		i_rst = 0;
		chk(pd, 1); chk(held, 1); chk(tri_s, 1); chk(buf_en, 0); chk(lock, 0); chk(rdiv, 1);
		ce = 1;
		rf = rw(14'h0064, 0);
		ctl = cw(2'h0, 0, 1, 1, 0, 0);
		fb = fw(5'h07, 13'h0064, 1);
		go(0, 2'h0);
		chk(pd, 0); chk(buf_en, 1); chk(rdiv, 100);
		chk(presc, 1); chk(sw, 7); chk(mn, 100);
		chk(tot, 18'h0_0647);
		chk(d2, 1); chk(d2p, 0);
		chk(cur, 5); chk(pol, 1);
		chk(rf_en, 0); chk(held, 0); chk(tri_s, 0);
		@(posedge ref_w);
		bands = 0;
		repeat (8) @(posedge ref_w);
		chk(bands[17:0], 4);
		// Lock needs three good rises, then five with precision set
		@(negedge ref_w); tick(1); ok = 1;
		rises(2); chk(lock, 0);
		rises(1); chk(lock, 1); chk(rf_en, 1);
		@(negedge ref_w); tick(1); ok = 0;
		rises(1); chk(lock, 0);
		rf = rw(14'h0064, 1);
		go(1, 2'h0);
		@(negedge ref_w); tick(1); ok = 1;
		rises(4); chk(lock, 0);
		rises(1); chk(lock, 1);
		ctl = cw(2'h0, 0, 0, 1, 1, 1);
		go(1, 2'h1);
		chk(cur, 3); chk(pol, 0); chk(held, 1); chk(tri_s, 1);
		fb = fw(5'h1f, 13'h1fff, 1);
		go(1, 2'h2);
		chk(cur, 5); chk(tot, 18'h2_000f);
		// Asynchronous power-down; a reference word still loads while down
		ctl = cw(2'h1, 0, 1, 0, 0, 0);
		go(1, 2'h1);
		chk(pd, 1); chk(lock, 0); chk(rf_en, 0); chk(buf_en, 0); chk(tri_s, 1); chk(held, 1);
		rf = rw(14'h00c8, 0);
		go(1, 2'h0);
		chk(rdiv, 200);
		ctl = cw(2'h0, 0, 1, 0, 0, 0);
		go(1, 2'h1);
		chk(pd, 0);
		// Synchronous power-down waits for the second reference rise
		run = 0;
		ctl = cw(2'h3, 0, 1, 0, 0, 0);
		go(1, 2'h1);
		chk(pd, 0);
		pulse(); chk(pd, 0);
		pulse(); chk(pd, 1);
		run = 1;
		ctl = cw(2'h0, 0, 1, 0, 0, 0);
		go(1, 2'h1);
		chk(pd, 0);
		ce = 0;
		tick(8); chk(pd, 1);
		ce = 1;
		tick(8); chk(pd, 0);
		end_sim();
	end
endmodule // synth_latch_power_control_tb
